// >>> include/sar_map.svh
// Constants for the converter readout: widths, codes and timing counts.
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH
`define SAR_RES_W          16
`define SAR_MSB            15
`define SAR_CODE_FS        16'hFFFF
`define SAR_CODE_ZS        16'h0000
`define SAR_CNT_W          12
`define SAR_FALL_W         5
`define SAR_FALLS_PLAIN    5'h10
`define SAR_FALLS_BUSY     5'h11
`define SAR_CLK_NS         8
`define SAR_CYC_UP(ns)     (((ns) + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_CYC_DN(ns)     ((ns) / `SAR_CLK_NS)
`define SAR_TCONV_NS       1600
`define SAR_TCONV_MIN_NS   500
`define SAR_TCONV_MAX_NS   2200
`define SAR_TCONV_CYC      `SAR_CYC_UP(`SAR_TCONV_NS)
`define SAR_TCONV_MIN_CYC  `SAR_CYC_DN(`SAR_TCONV_MIN_NS)
`define SAR_TCONV_MAX_CYC  `SAR_CYC_UP(`SAR_TCONV_MAX_NS)
`define SAR_SEL_PULSE_CYC  4
`define SAR_SCK_HALF_CYC   8
`define SAR_BUSY_TO_CYC    64
`endif

// >>> include/sar_pkg.sv
// Types shared by both ends of the converter readout link.
`include "sar_map.svh"
package sar_pkg;
	typedef enum logic [2:0] {
		DEV_ACQ  = 3'b001,
		DEV_CONV = 3'b010,
		DEV_READ = 3'b100
	} sar_dev_st_t;

	typedef enum logic [5:0] {
		H_IDLE = 6'b000001,
		H_CONV = 6'b000010,
		H_WAIT = 6'b000100,
		H_SEL  = 6'b001000,
		H_CLK  = 6'b010000,
		H_END  = 6'b100000
	} sar_host_st_t;

	typedef struct packed {
		sar_dev_st_t              st;
		logic                     cs_m;
		logic                     cs_s;
		logic                     cs_p;
		logic                     si_m;
		logic                     si_s;
		logic                     si_p;
		logic                     sck_m;
		logic                     sck_s;
		logic                     sck_p;
		logic                     chain;
		logic                     busy_en;
		logic [`SAR_CNT_W-1:0]    cnt;
		logic [`SAR_RES_W-1:0]    sh;
		logic [`SAR_FALL_W-1:0]   nfall;
		logic                     out;
		logic                     oe;
		logic                     acq;
		logic [`SAR_RES_W-1:0]    res;
		logic                     res_vld;
	} sar_dev_state_t;

	typedef struct packed {
		sar_host_st_t             st;
		logic                     sdo_m;
		logic                     sdo_s;
		logic                     four;
		logic                     busy;
		logic                     cs;
		logic                     si;
		logic                     sck;
		logic [`SAR_CNT_W-1:0]    cnt;
		logic [`SAR_FALL_W-1:0]   nb;
		logic [`SAR_RES_W:0]      sh;
		logic [`SAR_RES_W-1:0]    data;
		logic                     vld;
		logic                     tout;
		logic                     run;
	} sar_host_state_t;
endpackage

// >>> include/sar_link_if.sv
// Serial link between the converter and its host, with the pull-up on the data line.
`timescale 1ns/100ps
interface sar_link_if;
	logic convert_strobe;
	logic serial_in;
	logic serial_clock;
	logic serial_out;
	logic serial_out_oe;
	logic serial_out_line;

	// A released line floats high through the pull-up, which is what makes the busy bit visible.
	assign serial_out_line = serial_out_oe ? serial_out : 1'b1;

	modport dev (
		input  convert_strobe,
		input  serial_in,
		input  serial_clock,
		output serial_out,
		output serial_out_oe
	);

	modport host (
		output convert_strobe,
		output serial_in,
		output serial_clock,
		input  serial_out_line
	);
endinterface

// >>> core/sar_dev.sv
// Converter end: mode selection, conversion timing and serial readout.
//
// What this block does
// - Strobe rise samples serial_in, selects mode.
// - Tied serial_in and strobe always give chain.
// - Select mode busy if strobe/serial_in low.
// - Chain mode busy if clock high.
// - Host without busy waits maximum conversion time.
// - Select-mode conversion start releases serial_out immediately.
// - Conversion always completes, strobe ignored meanwhile.
// - Conversion end returns to powered-down acquisition.
// - 3-wire no busy: strobe high again timely.
// - 3-wire no busy: MSB on strobe fall.
// - Bit held across both clock edges.
// - 3-wire no busy: release at 16th fall.
// - 3-wire busy: hidden until done, strobe low.
// - Select-mode busy: drive low when conversion completes; chain busy drives high.
// - 3-wire busy: shift MSB first, release 17th.
// - 4-wire: host keeps strobe high throughout.
// - 4-wire: both lines low drives output low.
// - 4-wire no busy: serial_in high timely.
// - 4-wire no busy: serial_in low starts read.
// - Host avoids selecting several converters together.
// - Internal counter times conversion, no clock needed.
// - Straight binary result saturates at range ends.
`timescale 1ns/100ps
`include "sar_map.svh"
module sar_dev #(
	parameter int unsigned CONV_CYCLES = `SAR_TCONV_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	sar_link_if.dev                     link,
	input  wire logic [`SAR_RES_W-1:0]  sample_code,
	input  wire logic                   over_range,
	input  wire logic                   under_range,
	output logic      [`SAR_RES_W-1:0]  result_q,
	output logic                        result_valid_q,
	output logic                        acquiring_q,
	output logic                        converting_q
);

	////////////////////////////////////////////////////////////////////////////
	// Parameter check.

	generate
		if (CONV_CYCLES < 1 || CONV_CYCLES > 4095) begin : g_bad
			$error("Conversion cycle count out of range.");
		end
		// The bit counter must reach the release count of a busy read.
		if (`SAR_FALLS_BUSY >= (1 << `SAR_FALL_W) || `SAR_MSB + 1 != `SAR_RES_W) begin : g_bad_w
			$error("Bit counter or result width does not fit.");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// State.

	sar_pkg::sar_dev_state_t q;
	sar_pkg::sar_dev_state_t d;

	logic                  cs_rise;
	logic                  cs_fall;
	logic                  sck_fall;
	logic                  sel_now;
	logic                  sel_prev;
	logic                  sel_on;
	logic                  sel_off;
	logic [`SAR_RES_W-1:0] code_sat;
	logic [`SAR_FALL_W-1:0] nfall_inc;
	logic [`SAR_FALL_W-1:0] fall_lim;

	// Edges are taken from the second and third stage only, never the first.
	assign cs_rise   = q.cs_s & ~q.cs_p;
	assign cs_fall   = ~q.cs_s & q.cs_p;
	assign sck_fall  = ~q.sck_s & q.sck_p;
	assign sel_now   = ~(q.cs_s & q.si_s);
	assign sel_prev  = ~(q.cs_p & q.si_p);
	assign sel_on    = sel_now & ~sel_prev;
	assign sel_off   = ~sel_now & sel_prev;
	assign nfall_inc = q.nfall + `SAR_FALL_W'(1);
	assign fall_lim  = q.busy_en ? `SAR_FALLS_BUSY : `SAR_FALLS_PLAIN;

	// The analog side reports range overflow separately; the code is clamped here.
	assign code_sat = over_range ? `SAR_CODE_FS : (under_range ? `SAR_CODE_ZS : sample_code);

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		d = q;
		d.cs_m    = link.convert_strobe;
		d.cs_s    = q.cs_m;
		d.cs_p    = q.cs_s;
		d.si_m    = link.serial_in;
		d.si_s    = q.si_m;
		d.si_p    = q.si_s;
		d.sck_m   = link.serial_clock;
		d.sck_s   = q.sck_m;
		d.sck_p   = q.sck_s;
		d.res_vld = 1'b0;
		if (q.st != sar_pkg::DEV_CONV && cs_rise) begin
			// The level one cycle before the strobe edge decides, so a tied line reads low.
			d.st      = sar_pkg::DEV_CONV;
			d.chain   = ~q.si_p;
			d.busy_en = q.sck_p;
			d.cnt     = '0;
			d.nfall   = '0;
			d.oe      = 1'b0;
			d.out     = 1'b0;
			d.acq     = 1'b0;
		end else begin
			unique case (q.st)
				sar_pkg::DEV_ACQ: begin
					// Both lines low claims the shared line and pulls it low.
					d.oe  = ~q.cs_s & ~q.si_s;
					d.out = 1'b0;
				end
				sar_pkg::DEV_CONV: begin
					// Only the internal counter ends a conversion; strobe edges are not looked at.
					d.cnt = q.cnt + `SAR_CNT_W'(1);
					if (q.cnt == `SAR_CNT_W'(CONV_CYCLES - 1)) begin
						d.st      = sar_pkg::DEV_READ;
						d.acq     = 1'b1;
						d.res     = code_sat;
						d.sh      = code_sat;
						d.res_vld = 1'b1;
						d.nfall   = '0;
						if (q.chain) begin
							d.oe  = 1'b1;
							d.out = q.busy_en ? 1'b1 : code_sat[`SAR_MSB];
							if (!q.busy_en) begin
								d.sh = {code_sat[`SAR_MSB-1:0], 1'b0};
							end
						end else begin
							// Select mode reads the busy request from the lines as they stand at the last count.
							d.busy_en = ~q.cs_s | ~q.si_s;
							d.oe      = ~q.cs_s | ~q.si_s;
							d.out     = 1'b0;
						end
					end
				end
				sar_pkg::DEV_READ: begin
					// A read that loses its clock simply waits here; the next strobe rise restarts.
					if (q.chain) begin
						if (cs_fall) begin
							d.oe = 1'b0;
							d.st = sar_pkg::DEV_ACQ;
						end else if (sck_fall) begin
							d.out = q.sh[`SAR_MSB];
							d.sh  = {q.sh[`SAR_MSB-1:0], q.si_s};
						end
					end else if (sel_off) begin
						// Deselect ends the read at once, whatever the bit count.
						d.oe = 1'b0;
						d.st = sar_pkg::DEV_ACQ;
					end else if (sel_on && !q.busy_en && !q.oe && q.nfall == '0) begin
						// The shifter moves on here, so the first falling edge already shows the second bit.
						d.oe  = 1'b1;
						d.out = q.sh[`SAR_MSB];
						d.sh  = {q.sh[`SAR_MSB-1:0], 1'b0};
					end else if (sck_fall && q.oe) begin
						// A bit changes only after a falling edge, so it is stable over a whole period.
						d.nfall = nfall_inc;
						if (nfall_inc == fall_lim) begin
							d.oe = 1'b0;
							d.st = sar_pkg::DEV_ACQ;
						end else begin
							d.out = q.sh[`SAR_MSB];
							d.sh  = {q.sh[`SAR_MSB-1:0], 1'b0};
						end
					end
				end
				default: begin
					d.st = sar_pkg::DEV_ACQ;
					d.oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			// Sync stages reset to the idle pin levels, so no false strobe edge or selection follows reset.
			q       <= '0;
			q.st    <= sar_pkg::DEV_ACQ;
			q.acq   <= 1'b1;
			q.cs_s  <= 1'b0;
			q.si_s  <= 1'b1;
			q.si_m  <= 1'b1;
			q.si_p  <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign link.serial_out    = q.out;
	assign link.serial_out_oe = q.oe;
	assign result_q           = q.res;
	assign result_valid_q     = q.res_vld;
	assign acquiring_q        = q.acq;
	// The one-hot conversion bit is a flop of its own, so no decode sits on the output.
	assign converting_q       = q.st[1];

endmodule

// >>> core/sar_host.sv
// Host end: starts conversions and reads results in the select-mode variants.
`timescale 1ns/100ps
`include "sar_map.svh"
module sar_host #(
	parameter int unsigned TMAX_CYCLES = `SAR_TCONV_MAX_CYC,
	parameter int unsigned TMIN_CYCLES = `SAR_TCONV_MIN_CYC,
	parameter int unsigned PULSE_CYCLES = `SAR_SEL_PULSE_CYC,
	parameter int unsigned HALF_CYCLES = `SAR_SCK_HALF_CYC,
	parameter int unsigned TOUT_CYCLES = `SAR_BUSY_TO_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	sar_link_if.host                    link,
	input  wire logic                   start,
	input  wire logic                   four_wire,
	input  wire logic                   use_busy,
	output logic      [`SAR_RES_W-1:0]  data_q,
	output logic                        data_valid_q,
	output logic                        timeout_q,
	output logic                        running_q
);

	////////////////////////////////////////////////////////////////////////////
	// Parameter check.

	generate
		if (PULSE_CYCLES < 1 || PULSE_CYCLES >= TMIN_CYCLES || HALF_CYCLES < 6 ||
			TMAX_CYCLES + TOUT_CYCLES > 4095) begin : g_bad
			$error("Host timing parameters out of range.");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// State.

	sar_pkg::sar_host_state_t q;
	sar_pkg::sar_host_state_t d;

	logic [`SAR_FALL_W-1:0] nb_lim;

	assign nb_lim = q.busy ? `SAR_FALLS_BUSY : `SAR_FALLS_PLAIN;

	always_comb begin
		d = q;
		d.sdo_m = link.serial_out_line;
		d.sdo_s = q.sdo_m;
		d.vld   = 1'b0;
		d.tout  = 1'b0;
		unique case (q.st)
			sar_pkg::H_IDLE: begin
				d.cs  = 1'b0;
				d.si  = 1'b1;
				d.sck = 1'b0;
				if (start) begin
					d.st   = sar_pkg::H_CONV;
					d.cs   = 1'b1;
					d.four = four_wire;
					d.busy = use_busy;
					d.cnt  = '0;
					d.run  = 1'b1;
				end
			end
			sar_pkg::H_CONV: begin
				d.cnt = q.cnt + `SAR_CNT_W'(1);
				if (q.busy && q.cnt == `SAR_CNT_W'(PULSE_CYCLES - 1)) begin
					// Dropping the select line well before the shortest conversion asks for busy.
					if (q.four) begin
						d.si = 1'b0;
					end else begin
						d.cs = 1'b0;
					end
					d.st  = sar_pkg::H_WAIT;
					d.cnt = '0;
				end else if (!q.busy && q.cnt == `SAR_CNT_W'(TMAX_CYCLES - 1)) begin
					// Without busy the only safe point is after the longest conversion.
					d.st = sar_pkg::H_SEL;
				end
			end
			sar_pkg::H_WAIT: begin
				d.cnt = q.cnt + `SAR_CNT_W'(1);
				if (!q.sdo_s) begin
					d.st  = sar_pkg::H_CLK;
					d.cnt = '0;
					d.nb  = '0;
				end else if (q.cnt == `SAR_CNT_W'(TMAX_CYCLES + TOUT_CYCLES)) begin
					d.tout = 1'b1;
					d.st   = sar_pkg::H_END;
				end
			end
			sar_pkg::H_SEL: begin
				if (q.four) begin
					d.si = 1'b0;
				end else begin
					d.cs = 1'b0;
				end
				d.st  = sar_pkg::H_CLK;
				d.cnt = '0;
				d.nb  = '0;
			end
			sar_pkg::H_CLK: begin
				d.cnt = q.cnt + `SAR_CNT_W'(1);
				if (q.cnt == `SAR_CNT_W'(HALF_CYCLES - 1)) begin
					d.cnt = '0;
					if (!q.sck) begin
						// Sampling at the rise sits mid-bit, clear of the synchroniser delay.
						d.sck = 1'b1;
						d.sh  = {q.sh[`SAR_RES_W-1:0], q.sdo_s};
						d.nb  = q.nb + `SAR_FALL_W'(1);
					end else begin
						d.sck = 1'b0;
						if (q.nb == nb_lim) begin
							d.st = sar_pkg::H_END;
						end
					end
				end
			end
			sar_pkg::H_END: begin
				// Raising the strobe here would start a new conversion, so it goes low instead.
				d.cs   = 1'b0;
				d.si   = 1'b1;
				d.sck  = 1'b0;
				d.data = q.sh[`SAR_RES_W-1:0];
				d.vld  = ~q.tout;
				d.run  = 1'b0;
				d.st   = sar_pkg::H_IDLE;
			end
			default: begin
				d.st = sar_pkg::H_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			q       <= '0;
			q.st    <= sar_pkg::H_IDLE;
			q.si    <= 1'b1;
			q.sdo_m <= 1'b1;
			q.sdo_s <= 1'b1;
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign link.convert_strobe = q.cs;
	assign link.serial_in      = q.si;
	assign link.serial_clock   = q.sck;
	assign data_q              = q.data;
	assign data_valid_q        = q.vld;
	assign timeout_q           = q.tout;
	assign running_q           = q.run;

endmodule

// >>> test/sar_link_sva.sv
// Checker on the link between the converter end and the host end.
`timescale 1ns/100ps
module sar_link_sva #(
	parameter int unsigned CONV_CYCLES = 200
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic convert_strobe,
	input wire logic serial_in,
	input wire logic serial_clock,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////////////
	logic [9:0] since_q;
	logic [4:0] nfall_q;
	logic       cs_q;
	logic       sck_q;
	logic       oe_q;
	logic       busy_q;
	// The age starts saturated, so nothing fires before the first conversion.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			since_q <= 10'h3FF;
			nfall_q <= 5'h00;
			cs_q <= 1'b0;
			sck_q <= 1'b0;
			oe_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			cs_q <= convert_strobe;
			sck_q <= serial_clock;
			oe_q <= serial_out_oe;
			if (convert_strobe && !cs_q) begin
				since_q <= 10'h000;
			end else if (since_q != 10'h3FF) begin
				since_q <= since_q + 10'h001;
			end
			if (!serial_out_oe) begin
				nfall_q <= 5'h00;
			end else if (sck_q && !serial_clock) begin
				nfall_q <= nfall_q + 5'h01;
			end
			if (!serial_out_oe) begin
				busy_q <= 1'b0;
			end else if (!oe_q && since_q <= CONV_CYCLES + 6) begin
				busy_q <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	property p_start_hiz;
		$rose(convert_strobe) && serial_in |-> ##4 (!serial_out_oe) [*8];
	endproperty
	a_start_hiz: assert property (p_start_hiz) else $error("line driven after a conversion start");
	property p_bit_stable;
		serial_out_oe && $past(serial_out_oe) && serial_clock |-> $stable(serial_out);
	endproperty
	a_bit_stable: assert property (p_bit_stable) else $error("data bit moved while the clock was high");
	property p_busy_low;
		$rose(serial_out_oe) && since_q <= CONV_CYCLES + 6 |-> !serial_out;
	endproperty
	a_busy_low: assert property (p_busy_low) else $error("busy start bit not low");
	property p_no_early;
		$rose(serial_out_oe) |-> since_q >= CONV_CYCLES;
	endproperty
	a_no_early: assert property (p_no_early) else $error("line driven before conversion end");
	property p_busy_on;
		since_q == CONV_CYCLES + 8 && (!convert_strobe || !serial_in) |-> serial_out_oe && !serial_out;
	endproperty
	a_busy_on: assert property (p_busy_on) else $error("busy bit missing");
	property p_busy_off;
		since_q == CONV_CYCLES + 8 && convert_strobe && serial_in |-> !serial_out_oe;
	endproperty
	a_busy_off: assert property (p_busy_off) else $error("busy bit without request");
	property p_release_count;
		serial_out_oe && nfall_q == (busy_q ? 5'h11 : 5'h10) |-> ##[0:4] !serial_out_oe;
	endproperty
	a_release_count: assert property (p_release_count) else $error("line held past the last fall");
	property p_si_release;
		$rose(serial_in) |-> ##[0:4] !serial_out_oe;
	endproperty
	a_si_release: assert property (p_si_release) else $error("line held after deselect");
endmodule

// >>> test/sar_adc_serial_readout_tb.sv
// Bench joining both ends and reading through every select-mode variant.
`timescale 1ns/100ps
module sar_adc_serial_readout_tb;
	localparam int unsigned CONV = 20;
	logic        clk;
	logic        sys_rst;
	logic        start;
	logic        four_wire;
	logic        use_busy;
	logic        over_range;
	logic        under_range;
	logic [15:0] sample_code;
	logic [15:0] result_q;
	logic [15:0] data_q;
	logic [15:0] mon_q;
	logic        first_q;
	logic        result_valid_q;
	logic        acquiring_q;
	logic        converting_q;
	logic        data_valid_q;
	logic        timeout_q;
	logic        running_q;
	logic [15:0] codes [4] = '{16'hA5C3, 16'h0001, 16'h8000, 16'h7FFE};
	int          n_errors = 0;
	int          n_compared = 0;
	int          n_bits = 0;
	int          n_res = 0;
	int          cyc = 0;
	sar_link_if link_if ();
	sar_dev #(.CONV_CYCLES(CONV)) sar_dev_inst (.clk(clk), .sys_rst(sys_rst), .link(link_if),
		.sample_code(sample_code), .over_range(over_range), .under_range(under_range), .result_q(result_q),
		.result_valid_q(result_valid_q), .acquiring_q(acquiring_q), .converting_q(converting_q));
	sar_host #(.TMAX_CYCLES(30), .TMIN_CYCLES(10)) sar_host_inst (.clk(clk), .sys_rst(sys_rst), .link(link_if),
		.start(start), .four_wire(four_wire), .use_busy(use_busy), .data_q(data_q),
		.data_valid_q(data_valid_q), .timeout_q(timeout_q), .running_q(running_q));
	sar_link_sva #(.CONV_CYCLES(CONV)) sar_link_sva_inst (.clk(clk), .sys_rst(sys_rst),
		.convert_strobe(link_if.convert_strobe), .serial_in(link_if.serial_in),
		.serial_clock(link_if.serial_clock), .serial_out(link_if.serial_out),
		.serial_out_oe(link_if.serial_out_oe));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// The wire is watched on its own, so a host that reorders bits cannot hide a device fault.
	always @(posedge link_if.serial_clock) begin
		if (link_if.serial_out_oe === 1'b1) begin
			if (n_bits == 0) first_q = link_if.serial_out_line;
			mon_q = {mon_q[14:0], link_if.serial_out_line};
			n_bits++;
		end
	end
	always @(posedge clk) begin
		if (result_valid_q === 1'b1) n_res++;
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic read_once(input logic four, input logic busy, input logic [15:0] code, input logic ovr,
		input logic und, input logic [15:0] exp);
		int w;
		@(posedge clk);
		#1;
		four_wire = four;
		use_busy = busy;
		sample_code = code;
		over_range = ovr;
		under_range = und;
		n_bits = 0;
		n_res = 0;
		start = 1'b1;
		@(posedge clk);
		#1;
		start = 1'b0;
		w = 0;
		while (data_valid_q !== 1'b1 && timeout_q !== 1'b1 && w < 2000) begin
			@(posedge clk);
			#1;
			w++;
		end
		check("timeout", timeout_q, 1'b0);
		check("host data", data_q, exp);
		check("wire data", mon_q, exp);
		check("wire bits", n_bits, busy ? 17 : 16);
		if (busy) check("busy bit", first_q, 1'b0);
		else check("first bit", first_q, exp[15]);
		check("result", result_q, exp);
		check("result pulses", n_res, 1);
		check("acquiring", acquiring_q, 1'b1);
		check("converting", converting_q, 1'b0);
		w = 0;
		while (running_q !== 1'b0 && w < 100) begin
			@(posedge clk);
			#1;
			w++;
		end
		check("running", running_q, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		start = 1'b0;
		four_wire = 1'b0;
		use_busy = 1'b0;
		over_range = 1'b0;
		under_range = 1'b0;
		sample_code = 16'h0000;
		mon_q = 16'h0000;
		first_q = 1'b1;
		repeat (4) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		check("idle oe", link_if.serial_out_oe, 1'b0);
		// Each read starts as soon as the previous one lets go, back to back.
		for (int i = 0; i < 4; i++) begin
			read_once(i[1], i[0], codes[i], 1'b0, 1'b0, codes[i]);
		end
		read_once(1'b0, 1'b1, 16'h1234, 1'b1, 1'b0, 16'hFFFF);
		read_once(1'b0, 1'b0, 16'h1234, 1'b0, 1'b1, 16'h0000);
		read_once(1'b1, 1'b1, 16'h5555, 1'b1, 1'b1, 16'hFFFF);
		stop_test();
	end
endmodule
